// ---- common/hbsr_pkg.sv ----
package hbsr_pkg;
	localparam int DATA_W    = 64;
	localparam int GRP_W     = 16;
	localparam int NGRP      = 4;
	localparam int REQ_W     = 5;
	localparam int RESP_W    = 3;
	localparam int FIFO_DEPTH = 8;
	localparam int BEATS     = 4;
	// Response codes
	localparam logic [2:0] RESP_IDLE   = 3'h0;
	localparam logic [2:0] RESP_RETRY  = 3'h1;
	localparam logic [2:0] RESP_DEFER  = 3'h2;
	localparam logic [2:0] RESP_RSVD   = 3'h3;
	localparam logic [2:0] RESP_HFAIL  = 3'h4;
	localparam logic [2:0] RESP_NODATA = 3'h5;
	localparam logic [2:0] RESP_IWB    = 3'h6;
	localparam logic [2:0] RESP_NORMAL = 3'h7;
	// Request command: bit in first half that marks a write
	localparam int REQ_WR_BIT = 1;
	localparam int SNOOP_STALL_CYC = 2;
	typedef enum logic [2:0] {HBSR_IDLE, HBSR_REQB, HBSR_SNOOP, HBSR_DATA, HBSR_RESP} hbsr_state_t;
endpackage

// ---- hw/hbsr_fifo.sv ----
module hbsr_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
	logic             wr, rd;
	always_comb
	begin
		in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
		out_valid = wp_r != rp_r;
		wr        = in_valid && in_ready;
		rd        = out_valid && out_ready;
		wp_nxt    = wp_r + (AW+1)'(wr);
		rp_nxt    = rp_r + (AW+1)'(rd);
		out_data  = mem_r[rp_r[AW-1:0]];
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
		if (wr)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end
endmodule // hbsr_fifo

// ---- hw/hbsr_port.sv ----
// Function
// (R01) Data moves four beats per bus clock on strobes
// (R02) Strobes 3,2,0 time groups 63:48,47:32,15:0; inbound capture here times all groups on strobe pair 0
// (R03) Strobe 1 times bits 31:16, flag 1; inbound capture here times these bits on strobe pair 0
// (R04) Clean hit flags unmodified cached copy
// (R05) Dirty hit flags modified copy, owner supplies
// (R06) Both hits together stretch the snoop window
// (R07) Locked sequence blocks snoopable side accesses
// (R08) Request command sent in both request halves
// (R09) First half type, second half attributes
// (R10) Target ready only when data can move
// (R11) Three-bit response code, 000 idle
// (R12) Codes retry, defer, nodata, writeback, normal
// (R13) Never drive reserved or hard failure codes
// (R14) Address strobe marks first request cycle
// (R15) Address and data inverted on bus
module hbsr_port #(
	parameter int DEPTH = hbsr_pkg::FIFO_DEPTH
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic [hbsr_pkg::DATA_W-1:0]   host_data_bus_in,
	output logic      [hbsr_pkg::DATA_W-1:0]   host_data_bus_out,
	output logic                               host_data_bus_oe,
	input  wire logic [hbsr_pkg::NGRP-1:0]     data_inversion_flag_in,
	output logic      [hbsr_pkg::NGRP-1:0]     data_inversion_flag_out,
	input  wire logic [hbsr_pkg::NGRP-1:0]     data_strobe_true_in,
	input  wire logic [hbsr_pkg::NGRP-1:0]     data_strobe_comp_in,
	output logic      [hbsr_pkg::NGRP-1:0]     data_strobe_true_out,
	output logic      [hbsr_pkg::NGRP-1:0]     data_strobe_comp_out,
	input  wire logic                          clean_snoop_hit_in,
	output logic                               clean_snoop_hit_out,
	input  wire logic                          dirty_snoop_hit_in,
	output logic                               dirty_snoop_hit_out,
	output logic                               snoop_oe,
	input  wire logic                          atomic_lock_request_n,
	input  wire logic                          request_phase_strobe_n,
	input  wire logic [hbsr_pkg::REQ_W-1:0]    request_command_n,
	output logic                               target_ready_for_data_n,
	output logic      [hbsr_pkg::RESP_W-1:0]   response_code_n,
	input  wire logic                          snoop_stall_req,
	input  wire logic                          cache_clean_hit,
	input  wire logic                          cache_dirty_hit,
	input  wire logic                          retry_req,
	input  wire logic                          defer_req,
	output logic                               side_access_block,
	output logic      [hbsr_pkg::REQ_W-1:0]    req_type,
	output logic      [hbsr_pkg::REQ_W-1:0]    req_attr,
	output logic                               req_valid,
	output logic      [hbsr_pkg::DATA_W-1:0]   wr_data,
	output logic                               wr_valid,
	input  wire logic                          wr_ready,
	input  wire logic [hbsr_pkg::DATA_W-1:0]   rd_data,
	input  wire logic                          rd_valid,
	output logic                               rd_ready
);
	localparam int G = hbsr_pkg::GRP_W;
	localparam int N = hbsr_pkg::NGRP;

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for all bus inputs except the unused snoop hit inputs
	logic [hbsr_pkg::DATA_W-1:0] d_s1_r, d_s2_r;
	logic [N-1:0] inv_s1_r, inv_s2_r, st_s1_r, st_s2_r, sc_s1_r, sc_s2_r, st_d_r;
	logic [hbsr_pkg::REQ_W-1:0] req_s1_r, req_s2_r;
	logic lk_s1_r, lk_s2_r, ads_s1_r, ads_s2_r;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			d_s1_r   <= '0;
			d_s2_r   <= '0;
			inv_s1_r <= '0;
			inv_s2_r <= '0;
			st_s1_r  <= '0;
			st_s2_r  <= '0;
			sc_s1_r  <= '0;
			sc_s2_r  <= '0;
			st_d_r   <= '0;
			req_s1_r <= '0;
			req_s2_r <= '0;
			lk_s1_r  <= 1'b1;
			lk_s2_r  <= 1'b1;
			ads_s1_r <= 1'b1;
			ads_s2_r <= 1'b1;
		end
		else
		begin
			d_s1_r   <= host_data_bus_in;
			d_s2_r   <= d_s1_r;
			inv_s1_r <= data_inversion_flag_in;
			inv_s2_r <= inv_s1_r;
			st_s1_r  <= data_strobe_true_in;
			st_s2_r  <= st_s1_r;
			sc_s1_r  <= data_strobe_comp_in;
			sc_s2_r  <= sc_s1_r;
			st_d_r   <= st_s2_r;
			req_s1_r <= request_command_n;
			req_s2_r <= req_s1_r;
			lk_s1_r  <= atomic_lock_request_n;
			lk_s2_r  <= lk_s1_r;
			ads_s1_r <= request_phase_strobe_n;
			ads_s2_r <= ads_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Inbound beat capture: strobe pair 0 alone times all four 16-bit groups
	function automatic logic [G-1:0] grp_decode(input logic [G-1:0] raw, input logic inv_n);
		// Bus carries inverted data; flag low means group sent inverted again
		grp_decode = inv_n ? ~raw : raw; // [R15]
	endfunction
	logic [hbsr_pkg::DATA_W-1:0] beat_data;
	logic [N-1:0] grp_edge;
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_grp
			assign grp_edge[gi] = (st_s2_r[gi] != st_d_r[gi]) && (st_s2_r[gi] != sc_s2_r[gi]); // [R01]
			assign beat_data[gi*G +: G] = grp_decode(d_s2_r[gi*G +: G], inv_s2_r[gi]); // [R02] [R03]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Request, snoop and response control
	hbsr_pkg::hbsr_state_t st_r, st_nxt;
	logic [hbsr_pkg::REQ_W-1:0] type_r, type_nxt, attr_r, attr_nxt;
	logic [1:0] beat_r, beat_nxt, stall_r, stall_nxt;
	logic [2:0] resp_r, resp_nxt;
	logic lock_r, lock_nxt, wr_r, wr_nxt, trdy_r, trdy_nxt, hit_r, dirty_snoop_hit_r, hit_nxt, dirty_snoop_hit_nxt;
	logic rq_r, rq_nxt, snoe_r, snoe_nxt, drv_r, drv_nxt;
	// Dirty hit kept until the response picks implicit writeback
	logic mod_r, mod_nxt;
	logic in_ready, fifo_out_valid;
	logic ads_seen;
	assign ads_seen = !ads_s2_r; // [R14]

	always_comb
	begin
		st_nxt = st_r; type_nxt = type_r; attr_nxt = attr_r; beat_nxt = beat_r;
		stall_nxt = stall_r; resp_nxt = hbsr_pkg::RESP_IDLE; wr_nxt = wr_r;
		trdy_nxt = 1'b0; hit_nxt = 1'b0; dirty_snoop_hit_nxt = 1'b0; snoe_nxt = 1'b0;
		rq_nxt = 1'b0; drv_nxt = 1'b0; lock_nxt = lock_r;
		mod_nxt = mod_r;
		if (lk_s2_r)
			lock_nxt = 1'b0;
		else if (ads_seen)
			lock_nxt = 1'b1; // [R07]
		unique case (st_r)
			hbsr_pkg::HBSR_IDLE:
				if (ads_seen)
				begin
					type_nxt = ~req_s2_r; // [R08] [R09]
					st_nxt   = hbsr_pkg::HBSR_REQB;
				end
			hbsr_pkg::HBSR_REQB:
			begin
				attr_nxt  = ~req_s2_r; // [R09]
				wr_nxt    = type_r[hbsr_pkg::REQ_WR_BIT];
				rq_nxt    = 1'b1;
				stall_nxt = 2'(hbsr_pkg::SNOOP_STALL_CYC);
				st_nxt    = hbsr_pkg::HBSR_SNOOP;
			end
			hbsr_pkg::HBSR_SNOOP:
			begin
				snoe_nxt = 1'b1;
				if (snoop_stall_req && stall_r != 2'h0)
				begin
					hit_nxt   = 1'b1; // [R06]
					dirty_snoop_hit_nxt  = 1'b1;
					stall_nxt = stall_r - 2'h1;
				end
				else
				begin
					hit_nxt  = cache_clean_hit && !cache_dirty_hit; // [R04]
					dirty_snoop_hit_nxt = cache_dirty_hit; // [R05]
					mod_nxt  = cache_dirty_hit;
					beat_nxt = '0;
					st_nxt   = (retry_req || defer_req) ? hbsr_pkg::HBSR_RESP : hbsr_pkg::HBSR_DATA;
				end
			end
			hbsr_pkg::HBSR_DATA:
				if (wr_r)
				begin
					trdy_nxt = in_ready; // [R10]
					if (in_ready && grp_edge[0])
					begin
						beat_nxt = beat_r + 2'h1;
						if (beat_r == 2'(hbsr_pkg::BEATS-1))
							st_nxt = hbsr_pkg::HBSR_RESP;
					end
				end
				else if (rd_valid)
				begin
					drv_nxt  = 1'b1; // [R01]
					beat_nxt = beat_r + 2'h1;
					if (beat_r == 2'(hbsr_pkg::BEATS-1))
						st_nxt = hbsr_pkg::HBSR_RESP;
				end
			hbsr_pkg::HBSR_RESP:
			begin
				if (retry_req)
					resp_nxt = hbsr_pkg::RESP_RETRY; // [R12]
				else if (defer_req)
					resp_nxt = hbsr_pkg::RESP_DEFER;
				else if (mod_r) // [R05]
					resp_nxt = hbsr_pkg::RESP_IWB;
				else if (wr_r)
					resp_nxt = hbsr_pkg::RESP_NODATA;
				else
					resp_nxt = hbsr_pkg::RESP_NORMAL; // [R11] [R13]
				st_nxt = hbsr_pkg::HBSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_r <= hbsr_pkg::HBSR_IDLE; type_r <= '0; attr_r <= '0; beat_r <= '0;
			stall_r <= '0; resp_r <= hbsr_pkg::RESP_IDLE; lock_r <= 1'b0; wr_r <= 1'b0;
			trdy_r <= 1'b0; hit_r <= 1'b0; dirty_snoop_hit_r <= 1'b0; rq_r <= 1'b0;
			snoe_r <= 1'b0; drv_r <= 1'b0;
			mod_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt; type_r <= type_nxt; attr_r <= attr_nxt; beat_r <= beat_nxt;
			stall_r <= stall_nxt; resp_r <= resp_nxt; lock_r <= lock_nxt; wr_r <= wr_nxt;
			trdy_r <= trdy_nxt; hit_r <= hit_nxt; dirty_snoop_hit_r <= dirty_snoop_hit_nxt; rq_r <= rq_nxt;
			snoe_r <= snoe_nxt; drv_r <= drv_nxt;
			mod_r <= mod_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outbound read data, strobes and flags
	logic [hbsr_pkg::DATA_W-1:0] dout_r, dout_nxt;
	logic [N-1:0] stb_r, stb_nxt;
	always_comb
	begin
		dout_nxt = dout_r;
		stb_nxt  = stb_r;
		if (drv_nxt)
		begin
			dout_nxt = ~rd_data; // [R15]
			stb_nxt  = ~stb_r; // [R01] [R02] [R03]
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dout_r <= '0;
			stb_r  <= '0;
		end
		else
		begin
			dout_r <= dout_nxt;
			stb_r  <= stb_nxt;
		end
	end

	hbsr_fifo #(
		.WIDTH (hbsr_pkg::DATA_W),
		.DEPTH (DEPTH)
	) u_wfifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (beat_data),
		.in_valid  (st_r == hbsr_pkg::HBSR_DATA && wr_r && grp_edge[0]),
		.in_ready  (in_ready),
		.out_data  (wr_data),
		.out_valid (fifo_out_valid),
		.out_ready (wr_ready)
	);

	assign wr_valid                = fifo_out_valid;
	assign rd_ready                = st_r == hbsr_pkg::HBSR_DATA && !wr_r;
	assign host_data_bus_out       = dout_r;
	assign host_data_bus_oe        = drv_r;
	assign data_inversion_flag_out = '1;
	assign data_strobe_true_out    = stb_r;
	assign data_strobe_comp_out    = ~stb_r;
	assign clean_snoop_hit_out     = !hit_r;
	assign dirty_snoop_hit_out     = !dirty_snoop_hit_r;
	assign snoop_oe                = snoe_r;
	assign target_ready_for_data_n = !trdy_r;
	assign response_code_n         = ~resp_r;
	assign side_access_block       = lock_r; // [R07]
	assign req_type                = type_r;
	assign req_attr                = attr_r;
	assign req_valid               = rq_r;
endmodule // hbsr_port

// ---- tb/hbsr_cpu_model.sv ----
module hbsr_cpu_model (
	input  logic        clk,
	input  logic        trdy_n,
	output logic        ads_n,
	output logic        lock_n,
	output logic [4:0]  cmd_n,
	output logic [63:0] data,
	output logic [3:0]  inv_n,
	output logic [3:0]  stb_t,
	output logic [3:0]  stb_c
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		{ads_n, lock_n, cmd_n, data, stb_t, stb_c} = {7'h7f, 64'h0, 8'h0f};
		inv_n = 4'hf;
	end
	task automatic xact(input logic [4:0] t, input logic [4:0] a, input logic lk,
		input logic [63:0] d);
		@(posedge clk);
		ads_n  <= 1'b0;
		lock_n <= !lk;
		cmd_n  <= ~t;
		@(posedge clk);
		ads_n <= 1'b1;
		cmd_n <= ~a;
		@(posedge clk);
		cmd_n <= 5'h1f;
		if (t[hbsr_pkg::REQ_WR_BIT])
			for (int i = 0; i < 4; i++)
			begin
				for (int w = 0; w < 300 && trdy_n !== 1'b0; w++)
					@(posedge clk);
				// Odd beats go with the group flags low and data not inverted
				#1.5 inv_n = i[0] ? 4'h0 : 4'hf;
				data = i[0] ? d + 64'(i) : ~(d + 64'(i));
				#19 stb_c = stb_t;
				stb_t = ~stb_t;
				if (i < 3)
					#20;
			end
	endtask
	task automatic unlock;
		@(posedge clk);
		lock_n <= 1'b1;
	endtask
endmodule // hbsr_cpu_model

// ---- tb/hbsr_port_bench.sv ----
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module hbsr_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_n, host_data_bus_oe, snoop_oe, atomic_lock_request_n;
	logic        clean_snoop_hit_out, dirty_snoop_hit_out, request_phase_strobe_n;
	logic        target_ready_for_data_n, snoop_stall_req, cache_clean_hit, cache_dirty_hit;
	logic        retry_req, defer_req, side_access_block, req_valid, wr_valid, wr_ready;
	logic        rd_valid, rd_ready, saw_ch, saw_dh, saw_both;
	logic [63:0] host_data_bus_in, host_data_bus_out, wr_data, rd_data, cpu_d;
	logic [3:0]  data_inversion_flag_out, data_strobe_true_in, data_strobe_comp_in;
	logic [3:0]  data_inversion_flag_in, cpu_i;
	logic [3:0]  data_strobe_true_out, data_strobe_comp_out, cpu_t, cpu_c, st_q;
	logic [4:0]  request_command_n, req_type, req_attr;
	logic [2:0]  response_code_n, c;
	logic [63:0] cap[$];
	int          num_checks, miscompares;
	assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : cpu_d;
	assign data_strobe_true_in = host_data_bus_oe ? data_strobe_true_out : cpu_t;
	assign data_strobe_comp_in = host_data_bus_oe ? data_strobe_comp_out : cpu_c;
	assign data_inversion_flag_in = host_data_bus_oe ? data_inversion_flag_out : cpu_i;
	hbsr_port u_dut (.clk, .rst_n, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
		.data_inversion_flag_in, .data_inversion_flag_out, .data_strobe_true_in,
		.data_strobe_comp_in, .data_strobe_true_out, .data_strobe_comp_out,
		.clean_snoop_hit_in(clean_snoop_hit_out), .clean_snoop_hit_out,
		.dirty_snoop_hit_in(dirty_snoop_hit_out), .dirty_snoop_hit_out, .snoop_oe,
		.atomic_lock_request_n, .request_phase_strobe_n, .request_command_n,
		.target_ready_for_data_n, .response_code_n, .snoop_stall_req, .cache_clean_hit,
		.cache_dirty_hit, .retry_req, .defer_req, .side_access_block, .req_type, .req_attr,
		.req_valid, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready);
	hbsr_cpu_model u_cpu (.clk, .trdy_n(target_ready_for_data_n),
		.ads_n(request_phase_strobe_n), .lock_n(atomic_lock_request_n),
		.cmd_n(request_command_n), .data(cpu_d), .inv_n(cpu_i), .stb_t(cpu_t), .stb_c(cpu_c));
	always @(posedge clk)
	begin
		if (host_data_bus_oe && data_strobe_true_out != st_q)
			cap.push_back(host_data_bus_out);
		st_q <= data_strobe_true_out;
		saw_ch <= saw_ch | (!clean_snoop_hit_out & dirty_snoop_hit_out);
		saw_dh <= saw_dh | (clean_snoop_hit_out & !dirty_snoop_hit_out);
		saw_both <= saw_both | !(clean_snoop_hit_out | dirty_snoop_hit_out);
		if (rd_valid && rd_ready)
			rd_data <= rd_data + 64'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_resp;
		c = 3'h7;
		for (int w = 0; w < 400 && c === 3'h7; w++)
		begin
			@(posedge clk);
			#1 c = response_code_n;
		end
	endtask
	task automatic t_write;
		int n;
		n = 0;
		u_cpu.xact(5'h02, 5'h0c, 1'b0, 64'h1000);
		wait_resp();
		`CHK("type", 5'h02, req_type)
		`CHK("attr", 5'h0c, req_attr)
		`CHK("wr resp", ~hbsr_pkg::RESP_NODATA, c)
		u_cpu.xact(5'h02, 5'h01, 1'b0, 64'h2000);
		wait_resp();
		fork
			u_cpu.xact(5'h02, 5'h01, 1'b0, 64'h3000);
		join_none
		repeat (40) @(posedge clk);
		`CHK("trdy full", 1'b1, target_ready_for_data_n)
		wr_ready <= 1'b1;
		for (int w = 0; w < 600 && n < 12; w++)
		begin
			#1;
			if (wr_valid === 1'b1)
			begin
				`CHK("wr data", 64'h1000 * (n / 4 + 1) + n % 4, wr_data)
				n++;
			end
			@(posedge clk);
		end
		`CHK("wr count", 12, n)
		repeat (20) @(posedge clk);
	endtask
	task automatic t_read(input logic dirty);
		{cache_dirty_hit, cache_clean_hit, snoop_stall_req} <= {dirty, !dirty, 1'b1};
		rd_valid <= 1'b1;
		rd_data <= 64'h5000;
		cap.delete();
		@(negedge clk) {saw_ch, saw_dh, saw_both} = 3'h0;
		u_cpu.xact(5'h00, 5'h00, 1'b0, 64'h0);
		wait_resp();
		`CHK("rd resp", dirty ? ~hbsr_pkg::RESP_IWB : ~hbsr_pkg::RESP_NORMAL, c)
		`CHK("dirty hit", dirty, saw_dh)
		`CHK("clean hit", !dirty, saw_ch)
		`CHK("stall", 1'b1, saw_both)
		`CHK("beats", 4, cap.size())
		`CHK("inv out", 4'hf, data_inversion_flag_out)
		for (int i = 0; i < 4 && i < cap.size(); i++)
			`CHK("rd pins", ~(64'h5000 + 64'(i)), cap[i])
		rd_valid <= 1'b0;
	endtask
	task automatic t_retry_defer;
		for (int k = 0; k < 2; k++)
		begin
			{retry_req, defer_req} <= k ? 2'h1 : 2'h2;
			cap.delete();
			u_cpu.xact(5'h00, 5'h00, 1'b0, 64'h0);
			wait_resp();
			`CHK("rty/dfr", k ? ~hbsr_pkg::RESP_DEFER : ~hbsr_pkg::RESP_RETRY, c)
			`CHK("no beats", 0, cap.size())
		end
		{retry_req, defer_req} <= 2'h0;
	endtask
	task automatic t_lock;
		rd_valid <= 1'b1;
		u_cpu.xact(5'h00, 5'h00, 1'b1, 64'h0);
		wait_resp();
		`CHK("locked", 1'b1, side_access_block)
		u_cpu.unlock();
		repeat (8) @(posedge clk);
		`CHK("unlocked", 1'b0, side_access_block)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		{rst_n, snoop_stall_req, cache_clean_hit, cache_dirty_hit, retry_req} = 5'h0;
		{defer_req, wr_ready, rd_valid, rd_data, st_q} = '0;
		{saw_ch, saw_dh, saw_both} = 3'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_write();
		t_read(1'b0);
		t_read(1'b1);
		t_retry_defer();
		t_lock();
		finish_test();
	end
	initial
	begin
		#100000;
		miscompares++;
		finish_test();
	end
endmodule // hbsr_port_bench
bind hbsr_port hbsr_port_properties u_props (.clk, .rst_n, .response_code_n,
	.target_ready_for_data_n, .clean_snoop_hit_out, .dirty_snoop_hit_out, .snoop_oe,
	.side_access_block, .atomic_lock_request_n, .request_phase_strobe_n, .host_data_bus_oe,
	.req_valid, .data_strobe_true_out, .data_strobe_comp_out);

// ---- tb/hbsr_port_properties.sv ----
module hbsr_port_properties (
	input logic       clk,
	input logic       rst_n,
	input logic [2:0] response_code_n,
	input logic       target_ready_for_data_n,
	input logic       clean_snoop_hit_out,
	input logic       dirty_snoop_hit_out,
	input logic       snoop_oe,
	input logic       side_access_block,
	input logic       atomic_lock_request_n,
	input logic       request_phase_strobe_n,
	input logic       host_data_bus_oe,
	input logic       req_valid,
	input logic [3:0] data_strobe_true_out,
	input logic [3:0] data_strobe_comp_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	no_bad_code_a: assert property (response_code_n != 3'h4 && response_code_n != 3'h3)
		else $error("reserved or failure code driven");
	resp_one_a: assert property (response_code_n != 3'h7 |=> response_code_n == 3'h7)
		else $error("response held longer than one cycle");
	strobe_pair_a: assert property (data_strobe_comp_out == ~data_strobe_true_out)
		else $error("strobe pair not complementary");
	stall_hits_a: assert property (!clean_snoop_hit_out && !dirty_snoop_hit_out |-> snoop_oe)
		else $error("both hits outside snoop window");
	lock_set_a: assert property (!atomic_lock_request_n && !request_phase_strobe_n
		|-> ##[1:4] side_access_block) else $error("locked request not blocking");
	lock_clr_a: assert property ($rose(atomic_lock_request_n) |-> ##[1:4] !side_access_block)
		else $error("block kept after lock release");
	trdy_late_a: assert property (req_valid |-> target_ready_for_data_n)
		else $error("target ready before snoop");
	ads_req_a: assert property ($fell(request_phase_strobe_n) |-> ##[2:6] req_valid)
		else $error("request not decoded");
	oe_resp_a: assert property ($fell(host_data_bus_oe)
		|-> ##[0:6] response_code_n inside {3'h0, 3'h1}) else $error("no data response");
	cover property ($rose(host_data_bus_oe));
	cover property (response_code_n == 3'h6);
	cover property ($rose(side_access_block));
endmodule // hbsr_port_properties
